/* File: hdl/led_mix_pkg.sv */
// constants for the led intensity and colour-mix register bank
package led_mix_pkg;
  localparam int unsigned num_modules = 4;
  localparam int unsigned num_channels = 12;
  localparam logic [7:0] module0_intensity_addr = 8'h07;
  localparam logic [7:0] module1_intensity_addr = 8'h08;
  localparam logic [7:0] module2_intensity_addr = 8'h09;
  localparam logic [7:0] module3_intensity_addr = 8'h0a;
  localparam logic [7:0] channel0_mix_addr = 8'h0b;
  localparam logic [7:0] channel1_mix_addr = 8'h0c;
  localparam logic [7:0] channel2_mix_addr = 8'h0d;
  localparam logic [7:0] channel3_mix_addr = 8'h0e;
  localparam logic [7:0] channel4_mix_addr = 8'h0f;
  localparam logic [7:0] channel5_mix_addr = 8'h10;
  localparam logic [7:0] channel6_mix_addr = 8'h11;
  localparam logic [7:0] channel7_mix_addr = 8'h12;
  localparam logic [7:0] channel8_mix_addr = 8'h13;
  localparam logic [7:0] channel9_mix_addr = 8'h14;
  localparam logic [7:0] channel10_mix_addr = 8'h15;
  localparam logic [7:0] channel11_mix_addr = 8'h16;
  localparam logic [7:0] soft_reset_addr = 8'h17;
  localparam logic [7:0] intensity_reset = 8'hff;
  localparam logic [7:0] mix_reset = 8'h00;
  localparam logic [7:0] soft_reset_default = 8'h00;
  localparam logic [7:0] soft_reset_key = 8'hff;
endpackage

/* File: hdl/duty_calc.sv */
// one channel duty: intensity scaled by inverted mix value
`timescale 1ns/1ps
module duty_calc
  import led_mix_pkg::*;
(
  // operands
  input wire logic [7:0] intensity,
  input wire logic [7:0] mix,
  // result
  output logic [15:0] duty
);
  // mix counts down: ffh means none of the colour, so invert before scaling
  // both operands widened first so the product is never cut to eight bits
  assign duty = {8'h00, intensity} * {8'h00, 8'hff - mix};
endmodule // duty_calc

/* File: hdl/rgb_led_intensity_mix_regs.sv */
// intensity, colour-mix and soft reset registers feeding the pwm duty values
`timescale 1ns/1ps
module rgb_led_intensity_mix_regs
  import led_mix_pkg::*;
#(
  parameter int unsigned channels = num_channels
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port from the serial bus engine
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // shared bank control
  input wire logic [3:0] module_shared_control_select,
  input wire logic [7:0] bank_intensity,
  input wire logic [23:0] bank_mix,
  // per-channel duty to the pwm generators
  output logic [channels*16-1:0] duty
);
  // one record holds every register; rdata and duty sit here so outputs come off flops
  typedef struct packed {
    logic [num_modules-1:0][7:0] intensity;
    logic [channels-1:0][7:0] mix;
    logic [7:0] rdata;
    logic [channels-1:0][15:0] duty;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  // duty ahead of its output register, and the operands picked per channel
  logic [channels-1:0][15:0] duty_w;
  logic [channels-1:0][7:0] sel_int;
  logic [channels-1:0][7:0] sel_mix;

  function automatic logic is_mix(input logic [7:0] a);
    is_mix = (a >= channel0_mix_addr) && (a <= channel11_mix_addr);
  endfunction

  function automatic logic is_int(input logic [7:0] a);
    is_int = (a >= module0_intensity_addr) && (a <= module3_intensity_addr);
  endfunction

  // only the exact key restores defaults; any other byte at the reset address is dropped
  function automatic logic is_soft_key(input logic we, input logic [7:0] a,
                                       input logic [7:0] d);
    is_soft_key = we && (a == soft_reset_addr) && (d == soft_reset_key);
  endfunction

  // outside both register ranges: writes are dropped except the key at the soft reset address, reads give 00h
  function automatic logic is_unmapped(input logic [7:0] a);
    is_unmapped = !is_int(a) && !is_mix(a);
  endfunction

  // three channels per module; bank mix picks by colour position
  always_comb begin
    for (int c = 0; c < int'(channels); c++) begin
      if (module_shared_control_select[c/3]) begin
        sel_int[c] = bank_intensity;
        sel_mix[c] = bank_mix[(c%3)*8 +: 8];
      end else begin
        sel_int[c] = st_ff.intensity[c/3];
        sel_mix[c] = st_ff.mix[c];
      end
    end
  end

  for (genvar g = 0; g < channels; g++) begin : g_duty
    duty_calc duty_calc_i (
      .intensity(sel_int[g]),
      .mix(sel_mix[g]),
      .duty(duty_w[g])
    );
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.duty = duty_w;
    if (is_soft_key(wr_en, addr, wdata)) begin
      // defaults restored; duty follows one cycle later from the new values
      nxt_st.intensity = {num_modules{intensity_reset}};
      nxt_st.mix = {channels{mix_reset}};
    end else if (wr_en && is_int(addr)) begin
      nxt_st.intensity[2'(addr - module0_intensity_addr)] = wdata;
    end else if (wr_en && is_mix(addr)) begin
      nxt_st.mix[4'(addr - channel0_mix_addr)] = wdata;
    end
    if (rd_en) begin
      if (is_int(addr)) begin
        nxt_st.rdata = st_ff.intensity[2'(addr - module0_intensity_addr)];
      end else if (is_mix(addr)) begin
        nxt_st.rdata = st_ff.mix[4'(addr - channel0_mix_addr)];
      end else begin
        // soft reset is write-only and reads its default
        nxt_st.rdata = soft_reset_default;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.intensity <= {num_modules{intensity_reset}};
      st_ff.mix <= {channels{mix_reset}};
      st_ff.rdata <= 8'h00;
      st_ff.duty <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign duty = st_ff.duty;

  a_mod3_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == module3_intensity_addr |=> st_ff.intensity[3] == $past(wdata))
    else $error("module 3 intensity write lost");
  a_mix0_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel0_mix_addr |=> st_ff.mix[0] == $past(wdata))
    else $error("channel 0 mix write lost");
  a_mix11_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel11_mix_addr |=> st_ff.mix[11] == $past(wdata))
    else $error("channel 11 mix write lost");
  a_soft_reset: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == soft_reset_addr && wdata == soft_reset_key
    |=> st_ff.intensity[3] == intensity_reset && st_ff.mix[5] == mix_reset)
    else $error("soft reset did not restore defaults");
  a_reset_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd_en && addr == soft_reset_addr |=> rdata == 8'h00)
    else $error("soft reset register read not zero");
  a_int_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd_en && addr == module3_intensity_addr |=> rdata == $past(st_ff.intensity[3]))
    else $error("intensity readback wrong");
  a_duty_indep: assert property (@(posedge clock) disable iff (!arst_n)
    !module_shared_control_select[0] |=> duty[15:0] ==
    {8'h00, $past(st_ff.intensity[0])} * {8'h00, 8'hff - $past(st_ff.mix[0])})
    else $error("channel 0 duty wrong");
  a_duty_bank: assert property (@(posedge clock) disable iff (!arst_n)
    module_shared_control_select[3] |=> duty[11*16 +: 16] ==
    {8'h00, $past(bank_intensity)} * {8'h00, 8'hff - $past(bank_mix[23:16])})
    else $error("bank duty wrong");

  // every intensity address lands in its own module
  a_mod0_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == module0_intensity_addr |=> st_ff.intensity[0] == $past(wdata))
    else $error("module 0 intensity write lost");
  a_mod1_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == module1_intensity_addr |=> st_ff.intensity[1] == $past(wdata))
    else $error("module 1 intensity write lost");
  a_mod2_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == module2_intensity_addr |=> st_ff.intensity[2] == $past(wdata))
    else $error("module 2 intensity write lost");

  // mix addresses are consecutive, one per channel in order
  a_mix1_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel1_mix_addr |=> st_ff.mix[1] == $past(wdata))
    else $error("channel 1 mix write lost");
  a_mix2_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel2_mix_addr |=> st_ff.mix[2] == $past(wdata))
    else $error("channel 2 mix write lost");
  a_mix3_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel3_mix_addr |=> st_ff.mix[3] == $past(wdata))
    else $error("channel 3 mix write lost");
  a_mix4_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel4_mix_addr |=> st_ff.mix[4] == $past(wdata))
    else $error("channel 4 mix write lost");
  a_mix5_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel5_mix_addr |=> st_ff.mix[5] == $past(wdata))
    else $error("channel 5 mix write lost");
  a_mix6_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel6_mix_addr |=> st_ff.mix[6] == $past(wdata))
    else $error("channel 6 mix write lost");
  a_mix7_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel7_mix_addr |=> st_ff.mix[7] == $past(wdata))
    else $error("channel 7 mix write lost");
  a_mix8_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel8_mix_addr |=> st_ff.mix[8] == $past(wdata))
    else $error("channel 8 mix write lost");
  a_mix9_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel9_mix_addr |=> st_ff.mix[9] == $past(wdata))
    else $error("channel 9 mix write lost");
  a_mix10_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == channel10_mix_addr |=> st_ff.mix[10] == $past(wdata))
    else $error("channel 10 mix write lost");

  // readback of the mix ends and of anything unmapped
  a_mix0_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd_en && addr == channel0_mix_addr |=> rdata == $past(st_ff.mix[0]))
    else $error("channel 0 mix readback wrong");
  a_mix11_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd_en && addr == channel11_mix_addr |=> rdata == $past(st_ff.mix[11]))
    else $error("channel 11 mix readback wrong");
  a_unmapped_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd_en && is_unmapped(addr) |=> rdata == soft_reset_default)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !rd_en |=> $stable(rdata))
    else $error("read data moved without a read");

  // registers only move on a mapped write or the reset key
  a_idle_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !wr_en |=> $stable(st_ff.intensity) && $stable(st_ff.mix))
    else $error("register changed without a write");
  a_unmapped_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && is_unmapped(addr) && addr != soft_reset_addr
    |=> $stable(st_ff.intensity) && $stable(st_ff.mix))
    else $error("unmapped write changed a register");
  a_soft_ignore: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && addr == soft_reset_addr && wdata != soft_reset_key
    |=> $stable(st_ff.intensity) && $stable(st_ff.mix))
    else $error("soft reset acted on a byte other than the key");
  a_soft_reset_all: assert property (@(posedge clock) disable iff (!arst_n)
    is_soft_key(wr_en, addr, wdata) |=> st_ff.intensity == {num_modules{intensity_reset}}
    && st_ff.mix == {channels{mix_reset}})
    else $error("soft reset left a register off its default");

  // duty on the far channels and the other bank colours
  a_duty_ch11_indep: assert property (@(posedge clock) disable iff (!arst_n)
    !module_shared_control_select[3] |=> duty[11*16 +: 16] ==
    {8'h00, $past(st_ff.intensity[3])} * {8'h00, 8'hff - $past(st_ff.mix[11])})
    else $error("channel 11 duty wrong");
  a_bank_colour1: assert property (@(posedge clock) disable iff (!arst_n)
    module_shared_control_select[0] |=> duty[16 +: 16] ==
    {8'h00, $past(bank_intensity)} * {8'h00, 8'hff - $past(bank_mix[15:8])})
    else $error("bank colour 1 duty wrong");
  a_bank_colour2: assert property (@(posedge clock) disable iff (!arst_n)
    module_shared_control_select[0] |=> duty[32 +: 16] ==
    {8'h00, $past(bank_intensity)} * {8'h00, 8'hff - $past(bank_mix[23:16])})
    else $error("bank colour 2 duty wrong");
  a_full_mix: assert property (@(posedge clock) disable iff (!arst_n)
    !module_shared_control_select[0] && st_ff.intensity[0] == 8'hff && st_ff.mix[0] == 8'h00
    |=> duty[15:0] == 16'hfe01)
    else $error("full intensity and full mix not at top duty");
endmodule // rgb_led_intensity_mix_regs

/* File: testbench/host_model.sv */
// register host model issuing single-byte writes and reads
`timescale 1ns/1ps
module host_model (
  // register port
  input wire logic clock,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  // released enables drop to 0, address and data show inverted values so stale data cannot pass
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {wr_en, rd_en, addr, wdata} = {w, ~w, a, d};
    @(negedge clock);
    {wr_en, rd_en, addr, wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // host_model

/* File: testbench/test_rgb_led_intensity_mix_regs.sv */
// self-checking bench for the intensity and colour-mix register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_rgb_led_intensity_mix_regs;
  logic clock = 0, arst_n = 0, wr_en, rd_en, rd_d = 0;
  logic [7:0] addr, wdata, rdata, bi = 8'h00, e;
  logic [3:0] sel = 4'h0;
  logic [23:0] bm = 24'h0;
  logic [191:0] duty;
  logic [7:0] expq[$];
  logic [7:0] sh [0:255] = '{default: 8'h00};
  logic [31:0] lf = 32'h4258febd;
  int error_cnt = 0, checks = 0;
  initial forever #4 clock = ~clock;
  host_model host_model_i (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  rgb_led_intensity_mix_regs rgb_led_intensity_mix_regs_i (.clock(clock), .arst_n(arst_n),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .module_shared_control_select(sel), .bank_intensity(bi), .bank_mix(bm), .duty(duty));
  always @(posedge clock) rd_d <= rd_en;
  always @(negedge clock) if (rd_d) begin e = expq.pop_front(); `CHK(rdata, e) end
  function automatic logic [15:0] mul(input logic [7:0] i, input logic [7:0] m);
    return {8'h00, i} * {8'h00, 8'hff - m};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rd_all;
    for (int a = 6; a < 25; a++) begin
      expq.push_back(sh[a]);
      host_model_i.put(1'b0, 8'(a), 8'h00);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a > 6 && a < 23) sh[a] = d;
    host_model_i.put(1'b1, a, d);
  endtask
  task automatic dflt;
    for (int a = 7; a < 23; a++) sh[a] = a < 11 ? 8'hff : 8'h00;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20us;
    error_cnt++;
    final_report();
  end
  initial begin
    dflt();
    repeat (10) @(negedge clock);
    arst_n = 1;
    rd_all();
    $display("reset values done");
    for (int a = 7; a < 23; a++) begin
      lf = lfsr(lf);
      wr(8'(a), lf[7:0]);
    end
    wr(8'h18, 8'h33);
    wr(8'h17, 8'h5a);
    rd_all();
    $display("read back done");
    `CHK(duty[15:0], mul(sh[7], sh[11]))
    `CHK(duty[191:176], mul(sh[10], sh[22]))
    lf = lfsr(lf);
    {bi, bm} = lf;
    // modules 0 and 3 on bank values, 1 and 2 stay on their own registers
    sel = 4'h9;
    repeat (3) @(negedge clock);
    `CHK(duty[15:0], mul(bi, bm[7:0]))
    `CHK(duty[31:16], mul(bi, bm[15:8]))
    `CHK(duty[63:48], mul(sh[8], sh[14]))
    `CHK(duty[191:176], mul(bi, bm[23:16]))
    $display("bank select done");
    sel = 4'h0;
    wr(8'h17, 8'hff);
    dflt();
    rd_all();
    `CHK(duty[15:0], mul(8'hff, 8'h00))
    `CHK(duty[191:176], mul(8'hff, 8'h00))
    $display("soft reset done");
    repeat (3) @(negedge clock);
    final_report();
  end
endmodule // test_rgb_led_intensity_mix_regs
